//--- rtl/swc_config_regs.sv
// power-up configuration bank: straps, then serial memory words
// Function
// [RQ1] memory words valid only with signature word; sig_q resets to SIG_VALUE, so a pass that never writes word 0 is applied
// [RQ2] valid memory words replace strap values
// [RQ3] two-bit led mode, default 11
// [RQ4] storm enable drops broadcasts over threshold
// [RQ5] external port duplex bit, 1 full
// [RQ6] external port speed bit, 1 is 10M
// [RQ7] external port flow control when bit set
// [RQ8] external port used only when enabled
// [RQ9] discard frame after sixteen collisions
// [RQ10] hashing pair chosen once, end of reset
// [RQ11] aging removes expired entries, default 10
// [RQ12] all-pass forwards every frame, default off
// [RQ13] modified backoff caps at eight slots
// [RQ14] pause and backpressure default on; type gated
// [RQ15] tagged or upper-port frames queued high; code needs priority_class_enable, upper ports also upper_ports_high_priority
`default_nettype none
module swc_config_regs (
    input wire logic clk_i,                    // 100 MHz device clock
    input wire logic rst_n_i,                  // async reset, active low
    input wire logic ce_i,                     // clock enable
    input wire swc_pkg::swc_cfg_t strap_i,     // strap pin levels
    input wire logic ld_wr_i,                  // memory word strobe
    input wire logic [1:0] ld_addr_i,          // memory word index
    input wire logic [15:0] ld_data_i,         // memory word
    input wire logic ld_done_i,                // memory read finished
    input wire logic [1:0] rd_addr_i,          // readback index
    input wire logic bcast_frame_i,            // broadcast frame arrives
    input wire logic bcast_over_i,             // broadcast queue over limit
    input wire logic [4:0] coll_count_i,       // consecutive collisions
    input wire logic frame_tag_high_i,         // frame has high tag
    input wire logic [2:0] frame_port_i,       // receiving port
    input wire logic frame_valid_i,            // frame classify strobe
    output swc_pkg::swc_cfg_t cfg_o,           // active configuration
    output logic [1:0] bp_type_eff_o,          // gated backpressure type
    output logic [3:0] backoff_cap_o,          // 0 = standard backoff
    output logic [15:0] rd_data_o,             // readback word
    output logic strap_taken_o,                // straps latched
    output logic cfg_final_o,                  // configuration settled
    output logic cfg_from_mem_o,               // memory data applied
    output logic bcast_drop_o,                 // drop this broadcast
    output logic tx_discard_o,                 // discard transmit frame
    output logic queue_high_o                  // queue frame high
);
    // ==========================================
    // strap synchronisation
    swc_pkg::swc_cfg_t strap_s; // straps after two flops
    swc_sync #(.W($bits(swc_pkg::swc_cfg_t))) u_strap_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .d_i(strap_i),
        .q_o(strap_s)
    );

    // ==========================================
    // state
    swc_pkg::swc_cfg_t cfg_q; // active fields
    logic [15:0] sig_q;       // last word 0 seen
    logic [15:0] shadow_q [1:3]; // memory words held until done
    logic [1:0] settle_q;     // strap settle counter
    logic taken_q;            // straps latched
    logic final_q;            // load finished
    logic from_mem_q;         // memory won
    logic [1:0] bp_eff_q;     // gated type
    logic [3:0] cap_q;        // backoff cap
    logic [15:0] rd_q;        // readback
    logic drop_q, disc_q, high_q; // event answers

    // ==========================================
    // decode of memory words and readback
    wire sig_ok = (sig_q == swc_pkg::SIG_VALUE);
    wire apply_mem = ld_done_i && !final_q && taken_q && sig_ok; // see [RQ1]
    wire finish = ld_done_i && !final_q && taken_q;
    swc_pkg::swc_cfg_t mem_cfg; // fields taken from memory words
    swc_pkg::swc_cfg_t nxt_cfg; // next active fields
    wire [15:0] w1 = shadow_q[1];
    wire [15:0] w2 = shadow_q[2];
    wire [15:0] w3 = shadow_q[3];
    assign mem_cfg = '{
        led_display_select: w1[swc_pkg::LED_SEL_LSB +: 2],
        priority_class_enable: w2[swc_pkg::PRIO_EN_BIT],
        upper_ports_high_priority: w2[swc_pkg::UPPER_HI_BIT],
        backpressure_type: w2[swc_pkg::BP_TYPE_LSB +: 2],
        flow_8023x_enable: w2[swc_pkg::FLOW_8023X_BIT],
        backpressure_enable: w2[swc_pkg::BP_EN_BIT],
        broadcast_storm_drop_enable: w2[swc_pkg::BSTORM_BIT],
        ext_port_full_duplex: w3[swc_pkg::EXT_FDX_BIT],
        ext_port_speed_select: w3[swc_pkg::EXT_SPD_BIT],
        ext_port_flow_control: w3[swc_pkg::EXT_FLOW_BIT],
        ext_port_enable: w3[swc_pkg::EXT_EN_BIT],
        excess_collision_discard: w3[swc_pkg::COLL_DROP_BIT],
        address_hash_select: w3[swc_pkg::HASH_LSB +: 2],
        age_time_select: w3[swc_pkg::AGE_LSB +: 2],
        test_forward_everything: w3[swc_pkg::TEST_FORWARD_EVERYTHING_BIT],
        short_backoff_enable: w3[swc_pkg::SHORT_BO_BIT]
    };
    wire take_strap = !taken_q && (settle_q == swc_pkg::STRAP_SETTLE);
    // memory replaces every field, straps only until then
    assign nxt_cfg = apply_mem ? mem_cfg : strap_s; // see [RQ2]
    wire load_cfg = take_strap || apply_mem;

    // readback packs the active fields back into word layout, word 0 returns sig_q
    logic [15:0] rd_w; // readback word before the flop
    always_comb begin
        rd_w = 16'h0000;
        unique case (rd_addr_i)
            swc_pkg::OFF_SIG: rd_w = sig_q;
            swc_pkg::OFF_LED:
                rd_w[swc_pkg::LED_SEL_LSB +: 2] = cfg_q.led_display_select;
            swc_pkg::OFF_CTL1: begin
                rd_w[swc_pkg::PRIO_EN_BIT] = cfg_q.priority_class_enable;
                rd_w[swc_pkg::UPPER_HI_BIT] = cfg_q.upper_ports_high_priority;
                rd_w[swc_pkg::BP_TYPE_LSB +: 2] = cfg_q.backpressure_type;
                rd_w[swc_pkg::FLOW_8023X_BIT] = cfg_q.flow_8023x_enable;
                rd_w[swc_pkg::BP_EN_BIT] = cfg_q.backpressure_enable;
                rd_w[swc_pkg::BSTORM_BIT] = cfg_q.broadcast_storm_drop_enable;
            end
            swc_pkg::OFF_CTL2: begin
                rd_w[swc_pkg::EXT_FDX_BIT] = cfg_q.ext_port_full_duplex;
                rd_w[swc_pkg::EXT_SPD_BIT] = cfg_q.ext_port_speed_select;
                rd_w[swc_pkg::EXT_FLOW_BIT] = cfg_q.ext_port_flow_control;
                rd_w[swc_pkg::EXT_EN_BIT] = cfg_q.ext_port_enable;
                rd_w[swc_pkg::COLL_DROP_BIT] = cfg_q.excess_collision_discard;
                rd_w[swc_pkg::HASH_LSB +: 2] = cfg_q.address_hash_select;
                rd_w[swc_pkg::AGE_LSB +: 2] = cfg_q.age_time_select;
                rd_w[swc_pkg::TEST_FORWARD_EVERYTHING_BIT] = cfg_q.test_forward_everything;
                rd_w[swc_pkg::SHORT_BO_BIT] = cfg_q.short_backoff_enable;
            end
        endcase
    end

    // ==========================================
    // event decisions from active fields
    wire upper_port = (frame_port_i >= swc_pkg::PORT_SIX);
    wire drop_d = cfg_q.broadcast_storm_drop_enable && bcast_frame_i
                  && bcast_over_i; // see [RQ4]
    wire disc_d = cfg_q.excess_collision_discard
                  && (coll_count_i >= swc_pkg::COLL_LIMIT); // see [RQ9]
    // cos gates both high-priority paths
    wire high_d = frame_valid_i && cfg_q.priority_class_enable
                  && (frame_tag_high_i
                      || (cfg_q.upper_ports_high_priority
                          && upper_port)); // see [RQ15]
    wire [1:0] bp_eff_d = cfg_q.backpressure_enable ?
                          cfg_q.backpressure_type : 2'h0; // see [RQ14]
    wire [3:0] cap_d = cfg_q.short_backoff_enable ?
                       swc_pkg::BACKOFF_SHORT : 4'h0; // see [RQ13]

    // ==========================================
    // strap settle and load sequencing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_q <= 2'h0;
            taken_q <= 1'b0;
            final_q <= 1'b0;
            from_mem_q <= 1'b0;
        end else if (ce_i) begin
            if (!taken_q && settle_q != swc_pkg::STRAP_SETTLE)
                settle_q <= settle_q + 2'h1;
            if (take_strap)
                taken_q <= 1'b1;
            // one load only, so hashing cannot change later
            if (finish)
                final_q <= 1'b1; // see [RQ10]
            if (apply_mem)
                from_mem_q <= 1'b1;
        end
    end

    // active fields: defaults, then straps, then memory
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= swc_pkg::RST_CFG; // see [RQ3] [RQ14]
        end else if (ce_i && load_cfg) begin
            cfg_q <= nxt_cfg; // see [RQ5] [RQ6] [RQ7] [RQ8] [RQ11] [RQ12]
        end
    end

    // incoming memory words, ignored after the load ends
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sig_q <= swc_pkg::RST_SIG;
            for (int i = 1; i <= 3; i++)
                shadow_q[i] <= 16'h0000;
        end else if (ce_i && ld_wr_i && !final_q) begin
            if (ld_addr_i == swc_pkg::OFF_SIG)
                sig_q <= ld_data_i;
            else
                shadow_q[ld_addr_i] <= ld_data_i;
        end
    end

    // registered answers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 16'h0000;
            bp_eff_q <= 2'h0;
            cap_q <= swc_pkg::BACKOFF_SHORT;
            drop_q <= 1'b0;
            disc_q <= 1'b0;
            high_q <= 1'b0;
        end else if (ce_i) begin
            rd_q <= rd_w;
            bp_eff_q <= bp_eff_d;
            cap_q <= cap_d;
            drop_q <= drop_d;
            disc_q <= disc_d;
            high_q <= high_d;
        end
    end

    assign cfg_o = cfg_q;
    assign bp_type_eff_o = bp_eff_q;
    assign backoff_cap_o = cap_q;
    assign rd_data_o = rd_q;
    assign strap_taken_o = taken_q;
    assign cfg_final_o = final_q;
    assign cfg_from_mem_o = from_mem_q;
    assign bcast_drop_o = drop_q;
    assign tx_discard_o = disc_q;
    assign queue_high_o = high_q;

    // ==========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sig_gate_a: assert property ( // see [RQ1]
        ce_i && ld_done_i && !final_q && taken_q && sig_q != 16'h55aa
        |=> !cfg_from_mem_o && $stable(cfg_o))
        else $error("memory applied without signature");
    mem_wins_a: assert property ( // see [RQ2]
        apply_mem && ce_i |=> cfg_o == $past(mem_cfg) && cfg_from_mem_o)
        else $error("memory words did not replace straps");
    storm_drop_a: assert property ( // see [RQ4]
        ce_i |=> bcast_drop_o == $past(cfg_q.broadcast_storm_drop_enable
            && bcast_frame_i && bcast_over_i))
        else $error("broadcast drop wrong");
    coll_disc_a: assert property ( // see [RQ9]
        ce_i && cfg_q.excess_collision_discard && coll_count_i == 5'h10
        |=> tx_discard_o)
        else $error("no discard at sixteen collisions");
    coll_hold_a: assert property ( // see [RQ9]
        ce_i && coll_count_i < 5'h10 |=> !tx_discard_o)
        else $error("discard before sixteen collisions");
    hash_frozen_a: assert property ( // see [RQ10]
        final_q |=> $stable(cfg_o.address_hash_select))
        else $error("hash selection changed after load");
    backoff_cap_a: assert property ( // see [RQ13]
        ce_i && cfg_q.short_backoff_enable |=> backoff_cap_o == 4'h8)
        else $error("backoff cap not eight slots");
    bp_gate_a: assert property ( // see [RQ14]
        ce_i && !cfg_q.backpressure_enable |=> bp_type_eff_o == 2'h0)
        else $error("backpressure type leaks while disabled");
    prio_high_a: assert property ( // see [RQ15]
        ce_i && frame_valid_i && cfg_q.priority_class_enable
        && cfg_q.upper_ports_high_priority && frame_port_i == 3'h7
        |=> queue_high_o)
        else $error("upper port frame not queued high");
    prio_off_a: assert property ( // see [RQ15]
        ce_i && !cfg_q.priority_class_enable |=> !queue_high_o)
        else $error("high queue without class of service");
    strap_time_a: assert property ( // see [RQ2]
        $rose(taken_q) |-> $past(settle_q) == 2'h2)
        else $error("straps latched before settling");
endmodule
`default_nettype wire

//--- rtl/swc_pkg.sv
// package: offsets, field layout, reset values and types of the config bank
`default_nettype none
package swc_pkg;
    // ==========================================
    // word offsets (word index of each register)
    localparam logic [1:0] OFF_SIG = 2'h0;  // validity signature word
    localparam logic [1:0] OFF_LED = 2'h1;  // led display selection
    localparam logic [1:0] OFF_CTL1 = 2'h2; // switch control one
    localparam logic [1:0] OFF_CTL2 = 2'h3; // switch control two
    // ==========================================
    // reset values and constants
    localparam logic [15:0] SIG_VALUE = 16'h55aa; // word 0 pattern
    localparam logic [15:0] RST_SIG = 16'h55aa;   // word 0 reset
    localparam logic [1:0] RST_LED_SEL = 2'h3;    // link/act, col, fdx/col, spd
    localparam logic [1:0] RST_AGE = 2'h2;        // aging time default
    localparam logic [4:0] COLL_LIMIT = 5'h10;    // 16 consecutive collisions
    localparam logic [3:0] BACKOFF_SHORT = 4'h8;  // capped backoff, slots
    localparam logic [1:0] STRAP_SETTLE = 2'h2;   // cycles for strap sync
    localparam logic [2:0] PORT_SIX = 3'h6;       // first upper port
    // ==========================================
    // field positions, word 1
    localparam int LED_SEL_LSB = 0;
    // field positions, word 2
    localparam int PRIO_EN_BIT = 15;
    localparam int UPPER_HI_BIT = 14;
    localparam int BP_TYPE_LSB = 11;
    localparam int FLOW_8023X_BIT = 7;
    localparam int BP_EN_BIT = 4;
    localparam int BSTORM_BIT = 2;
    // field positions, word 3
    localparam int EXT_FDX_BIT = 12;
    localparam int EXT_SPD_BIT = 11;
    localparam int EXT_FLOW_BIT = 10;
    localparam int EXT_EN_BIT = 9;
    localparam int COLL_DROP_BIT = 7;
    localparam int HASH_LSB = 5;
    localparam int AGE_LSB = 3;
    localparam int TEST_FORWARD_EVERYTHING_BIT = 2;
    localparam int SHORT_BO_BIT = 1;
    // ==========================================
    // configuration carrier
    typedef struct packed {
        logic [1:0] led_display_select;      // led mode
        logic priority_class_enable;         // class of service
        logic upper_ports_high_priority;     // ports 6/7 high
        logic [1:0] backpressure_type;       // 00 carrier based
        logic flow_8023x_enable;             // full-duplex pause
        logic backpressure_enable;           // half-duplex bp
        logic broadcast_storm_drop_enable;   // storm guard
        logic ext_port_full_duplex;          // 1 full
        logic ext_port_speed_select;         // 1 = 10M
        logic ext_port_flow_control;         // 1 on
        logic ext_port_enable;               // 1 enabled
        logic excess_collision_discard;      // drop after 16
        logic [1:0] address_hash_select;     // hashing pair
        logic [1:0] age_time_select;         // aging time
        logic test_forward_everything;       // all-pass test
        logic short_backoff_enable;          // 8-slot cap
    } swc_cfg_t;
    localparam swc_cfg_t RST_CFG = '{
        led_display_select: RST_LED_SEL,
        priority_class_enable: 1'b0,
        upper_ports_high_priority: 1'b0,
        backpressure_type: 2'h0,
        flow_8023x_enable: 1'b1,
        backpressure_enable: 1'b1,
        broadcast_storm_drop_enable: 1'b0,
        ext_port_full_duplex: 1'b1,
        ext_port_speed_select: 1'b1,
        ext_port_flow_control: 1'b0,
        ext_port_enable: 1'b0,
        excess_collision_discard: 1'b0,
        address_hash_select: 2'h0,
        age_time_select: RST_AGE,
        test_forward_everything: 1'b0,
        short_backoff_enable: 1'b1
    };
endpackage
`default_nettype wire

//--- rtl/swc_sync.sv
// two-flop synchroniser for a group of strap levels
`default_nettype none
module swc_sync #(
    parameter int W = 1 // bits carried
) (
    input wire logic clk_i,          // device clock
    input wire logic rst_n_i,        // async reset, active low
    input wire logic ce_i,           // clock enable
    input wire logic [W-1:0] d_i,    // asynchronous levels
    output logic [W-1:0] q_o         // synchronised levels
);
    // ==========================================
    // first stage feeds the second only
    logic [W-1:0] meta_q; // first stage
    logic [W-1:0] sync_q; // second stage

    // both stages frozen together with the rest of the block
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

//--- verif/swc_config_regs_bench.sv
// self-checking bench of the configuration bank
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module swc_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // stimulus and observed signals
    logic clk = 1'b0;           // 100 MHz
    logic rst_n = 1'b0;         // active low reset
    swc_pkg::swc_cfg_t strap;   // strap levels
    logic go = 1'b0;            // starts a model pass
    logic [3:0][15:0] words;    // words the model sends
    logic ld_wr, ld_done;
    logic [1:0] ld_addr;
    logic [15:0] ld_data;
    logic [1:0] rd_addr = 2'h0;
    logic bc_f = 1'b0, bc_o = 1'b0, tag = 1'b0, fv = 1'b0;
    logic [4:0] coll = 5'h00;
    logic [2:0] port = 3'h0;
    swc_pkg::swc_cfg_t cfg;
    logic [1:0] bp_eff;
    logic [3:0] cap;
    logic [15:0] rd_data;
    logic taken, final_o, from_mem, drop, disc, high;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // straps: led 10, type 10, bp off, ext flow/en on, hash 01,
    // age 11, all-pass on, short backoff off
    localparam logic [19:0] S1 = 20'b10_0_0_10_0_0_0_0_0_1_1_0_01_11_1_0;
    // defaults during reset, field by field as the words lay them out
    localparam logic [19:0] E_RST = 20'b11_0_0_00_1_1_0_1_1_0_0_0_00_10_0_1;
    // fields carried by words fff1, c894, 86cf
    localparam logic [19:0] E_MEM = 20'b01_1_1_01_1_1_1_0_0_1_1_1_10_01_1_1;
    logic ce = 1'b1; // clock enable, dropped once to check the freeze
    always #5 clk = ~clk;
    // ==========================================
    // design and serial memory
    swc_config_regs dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
        .strap_i(strap), .ld_wr_i(ld_wr), .ld_addr_i(ld_addr),
        .ld_data_i(ld_data), .ld_done_i(ld_done), .rd_addr_i(rd_addr),
        .bcast_frame_i(bc_f), .bcast_over_i(bc_o), .coll_count_i(coll),
        .frame_tag_high_i(tag), .frame_port_i(port), .frame_valid_i(fv),
        .cfg_o(cfg), .bp_type_eff_o(bp_eff), .backoff_cap_o(cap),
        .rd_data_o(rd_data), .strap_taken_o(taken), .cfg_final_o(final_o),
        .cfg_from_mem_o(from_mem), .bcast_drop_o(drop),
        .tx_discard_o(disc), .queue_high_o(high));
    swc_mem_model mem (.clk_i(clk), .go_i(go), .words_i(words),
        .ld_wr_o(ld_wr), .ld_addr_o(ld_addr), .ld_data_o(ld_data),
        .ld_done_o(ld_done));
    // ==========================================
    // hang guard: whole run is under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // reset with straps set, defaults checked inside reset
    task automatic do_reset;
        strap = S1;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        `CHK("reset cfg", E_RST, cfg)
        `CHK("reset age", 2'h2, cfg.age_time_select)
        `CHK("reset pass", 1'b0, cfg.test_forward_everything)
        `CHK("reset pause", 1'b1, cfg.flow_8023x_enable)
        `CHK("reset cap", 4'h8, cap)
        #1 rst_n = 1'b1;
        for (int i = 0; i < 20 && taken !== 1'b1; i++) @(posedge clk);
        #1;
    endtask
    // one model pass; returns two edges after the done pulse, bounded,
    // so a refused late pass has really ended before anything is judged
    task automatic load(input logic [15:0] w0, w1, w2, w3);
        words = {w3, w2, w1, w0};
        go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        for (int i = 0; i < 20 && ld_done !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // readback: answer one edge after the index
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        rd_addr = a;
        @(posedge clk);
        #1 `CHK("readback", e, rd_data)
    endtask
    // one cycle of event inputs; answers land at the next edge
    task automatic ev(input logic f, o, t, v, input logic [4:0] c,
                      input logic [2:0] p);
        bc_f = f;
        bc_o = o;
        tag = t;
        fv = v;
        coll = c;
        port = p;
        @(posedge clk);
        #1;
    endtask
    // ==========================================
    // straps applied; gated outputs off; readback of the view
    task automatic t_straps;
        do_reset();
        `CHK("straps taken", 1'b1, taken)
        `CHK("not final", 1'b0, final_o)
        `CHK("strap cfg", S1, cfg)
        `CHK("bp type gated", 2'h0, bp_eff)
        `CHK("standard backoff", 4'h0, cap)
        rd(2'h0, 16'h55aa);
        rd(2'h1, 16'h0002);
        ev(1'b1, 1'b1, 1'b1, 1'b1, 5'h10, 3'h6);
        `CHK("storm off", 1'b0, drop)
        `CHK("discard off", 1'b0, disc)
        `CHK("cos off", 1'b0, high)
    endtask
    // wrong signature word: straps stay
    task automatic t_bad_sig;
        load(16'h55ab, 16'hfff1, 16'hc894, 16'h86cf);
        `CHK("final bad", 1'b1, final_o)
        `CHK("mem bad", 1'b0, from_mem)
        `CHK("cfg bad", S1, cfg)
    endtask
    // valid words replace every field; reserved bits read 0
    task automatic t_good_load;
        do_reset();
        load(16'h55aa, 16'hfff1, 16'hc894, 16'h86cf);
        `CHK("mem applied", 1'b1, from_mem)
        `CHK("cfg mem", E_MEM, cfg)
        `CHK("half duplex", 1'b0, cfg.ext_port_full_duplex)
        `CHK("100M", 1'b0, cfg.ext_port_speed_select)
        `CHK("ext flow", 1'b1, cfg.ext_port_flow_control)
        `CHK("ext en", 1'b1, cfg.ext_port_enable)
        `CHK("hash crc", 2'h2, cfg.address_hash_select)
        `CHK("age", 2'h1, cfg.age_time_select)
        `CHK("all pass", 1'b1, cfg.test_forward_everything)
        `CHK("bp type", 2'h1, bp_eff)
        `CHK("short cap", 4'h8, cap)
        rd(2'h1, 16'h0001);
        rd(2'h2, 16'hc894);
        rd(2'h3, 16'h06ce);
        // a second pass after settling is refused, done pulse included
        load(16'h55aa, 16'h0002, 16'h0000, 16'h1800);
        `CHK("late write", E_MEM, cfg)
        `CHK("late from mem", 1'b1, from_mem)
    endtask
    // enabled event paths, boundary counts and ports
    task automatic t_events;
        ev(1'b1, 1'b1, 1'b0, 1'b1, 5'h0f, 3'h6);
        `CHK("drop", 1'b1, drop)
        `CHK("coll 15", 1'b0, disc)
        `CHK("port 6 high", 1'b1, high)
        ev(1'b1, 1'b0, 1'b0, 1'b1, 5'h10, 3'h5);
        `CHK("under limit", 1'b0, drop)
        `CHK("coll 16", 1'b1, disc)
        `CHK("port 5 low", 1'b0, high)
        ev(1'b0, 1'b1, 1'b1, 1'b1, 5'h00, 3'h0);
        `CHK("no bcast", 1'b0, drop)
        `CHK("tag high", 1'b1, high)
        ev(1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 3'h7);
        `CHK("port 7 high", 1'b1, high)
        ev(1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 3'h7);
        `CHK("not valid", 1'b0, high)
        // enable low: answers hold although the inputs would flip them
        ce = 1'b0;
        ev(1'b1, 1'b1, 1'b1, 1'b1, 5'h10, 3'h6);
        `CHK("frozen drop", 1'b0, drop)
        `CHK("frozen discard", 1'b0, disc)
        `CHK("frozen high", 1'b0, high)
        ce = 1'b1;
    endtask
    // ==========================================
    // main sequence
    initial begin
        strap = S1;
        words = '0;
        t_straps();
        t_bad_sig();
        t_good_load();
        t_events();
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire

//--- verif/swc_mem_model.sv
// serial memory model: four words, then a done pulse
`default_nettype none
module swc_mem_model (
    input wire logic clk_i,               // device clock
    input wire logic go_i,                // start one read pass
    input wire logic [3:0][15:0] words_i, // word images 0..3
    output logic ld_wr_o,                 // word strobe
    output logic [1:0] ld_addr_o,         // word index
    output logic [15:0] ld_data_o,        // word data
    output logic ld_done_o                // pass finished
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // idle levels at time zero
    initial begin
        ld_wr_o = 1'b0;
        ld_addr_o = 2'h0;
        ld_data_o = 16'h0000;
        ld_done_o = 1'b0;
    end
    // ==========================================
    // one word per cycle, word 0 first
    always begin
        @(posedge clk_i);
        if (go_i === 1'b1) begin
            for (int i = 0; i < 4; i++) begin
                #1;
                ld_wr_o = 1'b1;
                ld_addr_o = 2'(i);
                ld_data_o = words_i[i];
                @(posedge clk_i);
            end
            // released lines show the inverse, not a stale word
            #1;
            ld_wr_o = 1'b0;
            ld_addr_o = ~ld_addr_o;
            ld_data_o = ~ld_data_o;
            ld_done_o = 1'b1;
            @(posedge clk_i);
            #1;
            ld_done_o = 1'b0;
        end
    end
endmodule
`default_nettype wire
